/* line_code_pkg.sv */
// Shared constants, word layouts and helpers for the DC-balanced 20-bit word codec
package line_code_pkg;

   // ************************************************************
   // Word geometry
   // ************************************************************
   localparam int WORD_BITS       = 16;
   localparam int CODE_BITS       = 4;
   localparam int LINE_BITS       = WORD_BITS + CODE_BITS;
   localparam int HALF_LINE_BITS  = 10;
   localparam int CTRL_LOW_BITS   = 7;
   localparam int CTRL_PAYLOAD    = 14;
   localparam int FIFO_DEPTH_DEF  = 8;

   // Bit 0 is w0 and goes onto the line first; bit 19 is c3 and goes last
   typedef struct packed {
      logic [CODE_BITS-1:0] coding;
      logic [WORD_BITS-1:0] word;
   } line_word_t;

   typedef enum logic [1:0] {
      KIND_IDLE    = 2'b00,
      KIND_DATA    = 2'b01,
      KIND_CONTROL = 2'b11
   } word_kind_t;

   typedef struct packed {
      word_kind_t           kind;
      logic                 flag;
      logic [WORD_BITS-1:0] payload;
   } tx_req_t;

   // ************************************************************
   // Coding fields, stored with c0 in bit 0
   // ************************************************************
   localparam logic [3:0] CF_DATA_F0   = 4'hB;
   localparam logic [3:0] CF_DATA_F1   = 4'hD;
   localparam logic [3:0] CF_CTRL_F0   = 4'hC;
   localparam logic [3:0] CF_CTRL_F1   = 4'hA;
   localparam logic [3:0] CF_CTRL_INV  = 4'h3;
   localparam logic [3:0] CF_ODD_A     = 4'h5;
   localparam logic [3:0] CF_ODD_B     = 4'hA;

   localparam logic [15:0] IDLE_PATTERN_A_WORD = 16'h01FF;
   localparam logic [15:0] IDLE_PATTERN_B_WORD = 16'h007F;
   // Held as {w8,w7}
   localparam logic [1:0]  CTRL_MARK_TRUE      = 2'b10;

   // ************************************************************
   // Scrambler and disparity
   // ************************************************************
   localparam logic [6:0]        SCRAMBLE_SEED     = 7'h5A;
   localparam int                FLAG_SCRAMBLE_TAP = 0;
   localparam int                W0_SCRAMBLE_TAP   = 1;
   localparam logic signed [7:0] ACC_RESET         = 8'sh00;
   localparam logic signed [7:0] ACC_LIMIT         = 8'sh28;
   localparam logic signed [7:0] LINE_BITS_S       = 8'sh14;

   function automatic logic [4:0] count_ones(input line_word_t w);
      logic [4:0] n;
      n = 5'h00;
      for (int i = 0; i < LINE_BITS; i++) begin
         n = n + {4'h0, w[i]};
      end
      return n;
   endfunction : count_ones

   function automatic logic [6:0] scramble_step(input logic [6:0] s);
      return {s[5:0], s[6] ^ s[5]};
   endfunction : scramble_step

endpackage : line_code_pkg

/* word_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module word_fifo #(
   parameter int WIDTH = 19,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   generate
      if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
         $error("word_fifo needs DEPTH of at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      fill;
   logic             do_wr;
   logic             do_rd;

   assign in_ready  = (fill != DEPTH[PW:0]);
   assign out_valid = (fill != '0);
   assign out_data  = mem[rd_ptr];
   assign do_wr     = in_valid && in_ready;
   assign do_rd     = out_valid && out_ready;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : bump

   always_ff @(posedge core_clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill   <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= bump(wr_ptr);
         end
         if (do_rd) begin
            rd_ptr <= bump(rd_ptr);
         end
         fill <= fill + {{PW{1'b0}}, do_wr} - {{PW{1'b0}}, do_rd};
      end
   end

endmodule : word_fifo

/* dc_balanced_word_line_codec.sv */
// Word encoder and decoder for the DC-balanced 20-bit line code
// How it works
// - Only data, control and idle words exist; coding field marks data, w7,w8 tell control from idle.
// - With no data or control word pending, an idle word is sent.
// - A word is 16 word-field bits w0..w15 then coding bits c0..c3.
// - Serial order starts at w0 and ends at c3.
// - Every coding field holds a master transition for per-word timing.
// - Outside enhanced mode an idle word rises once, at the master transition.
// - The encoder keeps line DC balance on its own by inverting words.
// - Data words carry all 16 bits, true or complemented, plus a flag.
// - Flag follows user flag when selected, else alternates internally outside enhanced mode.
// - Non-enhanced data coding: 1101/0010 for flag 0, 1011/0100 for flag 1.
// - Control words carry 14 low bits and the receiver marks them control.
// - Control bits 0..6 go to w0..w6, bits 7..13 to w9..w15.
// - Control w7,w8 are 01 with 0011 true; complemented, 10 and 1100.
// - Idle A is nine ones then zeros; idle B seven ones; coding 0011.
// - Receiver flags c1=c2, bad 1100 words, and, outside enhanced mode, 1010 or 0101.
// - Enhanced mode scrambles the flag at send and descrambles it at receive.
// - Enhanced mode also sends the flag in control and idle words.
// - Receiver shows the flag only for data words.
// - Enhanced mode scrambles w0 at send and restores it at receive.
// - Invert data or control words when their sign equals the running sign.
// - Idle words never invert; pattern A on low running sign, B on high.
// - Without user flag or enhanced mode the flag toggles per data word.
`timescale 1ns/100ps
module dc_balanced_word_line_codec
   import line_code_pkg::*;
#(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   input  wire logic                   core_clk,
   input  wire logic                   rst_b,
   input  wire logic [15:0]            tx_payload,
   input  wire logic                   data_word_request,
   input  wire logic                   control_word_request,
   input  wire logic                   user_flag_in,
   input  wire logic                   user_flag_select,
   input  wire logic                   enhanced_simplex_select,
   output logic                        tx_ready,
   input  wire logic                   line_ready,
   output line_code_pkg::line_word_t   line_word,
   output logic                        running_sign,
   input  wire line_code_pkg::line_word_t rx_word,
   output logic [15:0]                 rx_payload,
   output logic                        rx_flag,
   output logic                        rx_data_word,
   output logic                        control_word_indicator,
   output logic                        rx_error
);
   import line_code_pkg::*;

   generate
      if (FIFO_DEPTH < 2) begin : g_bad_depth
         $error("FIFO_DEPTH must be at least 2");
      end
   endgenerate

   // ************************************************************
   // Input buffering
   // ************************************************************
   tx_req_t           enq_req;
   tx_req_t           head;
   logic              head_valid;
   logic              pop;

   always_comb begin
      enq_req.kind    = data_word_request ? KIND_DATA : KIND_CONTROL;
      enq_req.flag    = user_flag_in;
      enq_req.payload = tx_payload;
   end

   word_fifo #(
      .WIDTH ($bits(tx_req_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .in_valid  (data_word_request || control_word_request),
      .in_ready  (tx_ready),
      .in_data   (enq_req),
      .out_valid (head_valid),
      .out_ready (line_ready),
      .out_data  (head)
   );

   assign pop = head_valid && line_ready;

   // ************************************************************
   // Encoder
   // ************************************************************
   logic signed [7:0] acc;
   logic [6:0]        tx_scramble;
   logic              alt_flag;
   word_kind_t        next_kind;
   word_kind_t        line_kind;
   logic              line_inverted;
   logic              data_flag;
   logic              flag_sent;
   logic              word_sign;
   logic              invert;
   line_word_t        built;
   line_word_t        next_line;
   logic signed [7:0] next_acc;

   assign running_sign = (acc > 8'sh00);

   always_comb begin
      next_kind = head_valid ? head.kind : KIND_IDLE;
      data_flag = user_flag_select ? head.flag :
                  (enhanced_simplex_select ? 1'b0 : alt_flag);
      flag_sent = ((next_kind == KIND_DATA) ? data_flag : 1'b0)
                  ^ (enhanced_simplex_select & tx_scramble[FLAG_SCRAMBLE_TAP]);
      unique case (next_kind)
         KIND_DATA: begin
            built.word   = head.payload;
            built.coding = flag_sent ? CF_DATA_F1 : CF_DATA_F0;
         end
         KIND_CONTROL: begin
            built.word   = {head.payload[CTRL_PAYLOAD-1:CTRL_LOW_BITS], CTRL_MARK_TRUE,
                            head.payload[CTRL_LOW_BITS-1:0]};
            built.coding = flag_sent ? CF_CTRL_F1 : CF_CTRL_F0;
         end
         KIND_IDLE: begin
            built.word   = running_sign ? IDLE_PATTERN_B_WORD : IDLE_PATTERN_A_WORD;
            built.coding = flag_sent ? CF_CTRL_F1 : CF_CTRL_F0;
         end
         default: begin
            built.word   = IDLE_PATTERN_A_WORD;
            built.coding = CF_CTRL_F0;
         end
      endcase
      built.word[0] = built.word[0] ^ (enhanced_simplex_select & tx_scramble[W0_SCRAMBLE_TAP]);
      word_sign = (count_ones(built) > 5'(HALF_LINE_BITS));
      // Inverting the whole word flips the coding field too, which is how true/inverted codes pair up
      invert    = (next_kind != KIND_IDLE) && (word_sign == running_sign);
      next_line = invert ? ~built : built;
      next_acc  = acc + ($signed({2'b00, count_ones(next_line), 1'b0}) - LINE_BITS_S);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         line_word     <= {CF_CTRL_F0, IDLE_PATTERN_A_WORD};
         line_kind     <= KIND_IDLE;
         line_inverted <= 1'b0;
      end else if (line_ready) begin
         line_word     <= next_line;
         line_kind     <= next_kind;
         line_inverted <= invert;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         acc <= ACC_RESET;
      end else if (line_ready) begin
         acc <= next_acc;
      end
   end

   // Stalls hold the sequence so both ends stay locked word for word
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tx_scramble <= SCRAMBLE_SEED;
      end else if (line_ready) begin
         tx_scramble <= scramble_step(tx_scramble);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         alt_flag <= 1'b0;
      end else if (line_ready && next_kind == KIND_DATA && !user_flag_select && !enhanced_simplex_select) begin
         alt_flag <= ~alt_flag;
      end
   end

   // ************************************************************
   // Decoder
   // ************************************************************
   logic [6:0]  rx_scramble;
   logic [3:0]  rcf;
   logic        r_is_data;
   logic        r_inv;
   line_word_t  uw;
   logic        r_flag;
   logic        r_ctrl;
   logic        r_err;

   always_comb begin
      rcf       = rx_word.coding;
      r_is_data = (rcf[0] == rcf[3]);
      r_inv     = r_is_data ? ~rcf[0] : rcf[0];
      uw        = r_inv ? ~rx_word : rx_word;
      uw.word[0] = uw.word[0] ^ (enhanced_simplex_select & rx_scramble[W0_SCRAMBLE_TAP]);
      r_flag    = (r_is_data ? ~uw.coding[1] : uw.coding[1])
                  ^ (enhanced_simplex_select & rx_scramble[FLAG_SCRAMBLE_TAP]);
      r_ctrl    = !r_is_data && (uw.word[8:7] == CTRL_MARK_TRUE);
      r_err     = (rcf[1] == rcf[2])
                  || (rcf == CF_CTRL_INV && !(rx_word.word[7] && !rx_word.word[8]))
                  || (!enhanced_simplex_select && (rcf == CF_ODD_A || rcf == CF_ODD_B));
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rx_scramble <= SCRAMBLE_SEED;
      end else begin
         rx_scramble <= scramble_step(rx_scramble);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rx_payload             <= 16'h0000;
         rx_flag                <= 1'b0;
         rx_data_word           <= 1'b0;
         control_word_indicator <= 1'b0;
         rx_error               <= 1'b0;
      end else begin
         rx_payload             <= r_ctrl ? {2'b00, uw.word[15:9], uw.word[6:0]} : uw.word;
         rx_flag                <= r_is_data && !r_err && r_flag;
         rx_data_word           <= r_is_data && !r_err;
         control_word_indicator <= r_ctrl && !r_err;
         rx_error               <= r_err;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   logic        prev_valid;
   logic        prev_flag;
   logic        sent_flag;
   logic        line_alt;

   assign sent_flag = ((line_inverted ? ~line_word.coding : line_word.coding) == CF_DATA_F1);

   // Only internally flagged data words alternate; user-flagged words must not seed the comparison
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         line_alt <= 1'b0;
      end else if (line_ready) begin
         line_alt <= (next_kind == KIND_DATA) && !user_flag_select && !enhanced_simplex_select;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         prev_valid <= 1'b0;
         prev_flag  <= 1'b0;
      end else if (line_ready && line_alt) begin
         prev_valid <= 1'b1;
         prev_flag  <= sent_flag;
      end
   end

   sequence s_idle_slot;
      line_ready && !head_valid;
   endsequence

   property p_idle_when_empty;
      @(posedge core_clk) disable iff (!rst_b)
         s_idle_slot |=> line_kind == KIND_IDLE && !line_inverted;
   endproperty
   a_idle_when_empty: assert property (p_idle_when_empty) else $error("idle not sent on empty queue");

   property p_idle_pattern_sign;
      @(posedge core_clk) disable iff (!rst_b)
         s_idle_slot ##0 (!enhanced_simplex_select) |=>
            line_word.word == ($past(running_sign) ? IDLE_PATTERN_B_WORD : IDLE_PATTERN_A_WORD);
   endproperty
   a_idle_pattern_sign: assert property (p_idle_pattern_sign) else $error("wrong idle pattern");

   property p_idle_plain_coding;
      @(posedge core_clk) disable iff (!rst_b)
         line_kind == KIND_IDLE && !$past(enhanced_simplex_select) && $past(line_ready) |->
            line_word.coding == CF_CTRL_F0;
   endproperty
   a_idle_plain_coding: assert property (p_idle_plain_coding) else $error("idle coding not 0011");

   property p_balance;
      @(posedge core_clk) disable iff (!rst_b)
         acc <= ACC_LIMIT && acc >= -ACC_LIMIT;
   endproperty
   a_balance: assert property (p_balance) else $error("running disparity out of bound");

   property p_invert_choice;
      @(posedge core_clk) disable iff (!rst_b)
         line_ready && head_valid |=>
            line_inverted == ($past(count_ones(built) > 5'(HALF_LINE_BITS)) == $past(running_sign));
   endproperty
   a_invert_choice: assert property (p_invert_choice) else $error("wrong inversion choice");

   property p_ctrl_marks;
      @(posedge core_clk) disable iff (!rst_b)
         line_kind == KIND_CONTROL |->
            line_word.word[8:7] == (line_inverted ? ~CTRL_MARK_TRUE : CTRL_MARK_TRUE)
            && line_word.coding[0] == line_inverted;
   endproperty
   a_ctrl_marks: assert property (p_ctrl_marks) else $error("control mark bits wrong");

   property p_flag_alternates;
      @(posedge core_clk) disable iff (!rst_b)
         prev_valid && line_alt && $past(line_ready) |->
            sent_flag != prev_flag;
   endproperty
   a_flag_alternates: assert property (p_flag_alternates) else $error("flag did not alternate");

   property p_rx_error;
      @(posedge core_clk) disable iff (!rst_b)
         rx_word.coding[1] == rx_word.coding[2] |=> rx_error && !rx_data_word && !control_word_indicator;
   endproperty
   a_rx_error: assert property (p_rx_error) else $error("bad coding not flagged");

   property p_rx_flag_data_only;
      @(posedge core_clk) disable iff (!rst_b)
         !rx_data_word |-> !rx_flag;
   endproperty
   a_rx_flag_data_only: assert property (p_rx_flag_data_only) else $error("flag shown off data word");

   property p_stall_hold;
      @(posedge core_clk) disable iff (!rst_b)
         !line_ready |=> $stable(line_word) && $stable(acc);
   endproperty
   a_stall_hold: assert property (p_stall_hold) else $error("line word moved during stall");

endmodule : dc_balanced_word_line_codec

/* far_end_model.sv */
// Far-side model: serialiser handshake and remote transmitter feeding the receiver
`timescale 1ns/100ps
module far_end_model
   import line_code_pkg::*;
(
   input  wire logic                      core_clk,
   input  wire logic                      rst_b,
   input  wire logic                      slow,
   input  wire line_code_pkg::line_word_t rx_src,
   output logic                           line_ready,
   output line_code_pkg::line_word_t      rx_word
);
   // ************************************************************
   // Serialiser acceptance and remote words
   // ************************************************************
   logic [2:0] phase;

   // Slow mode takes two words in five, so the FIFO fills while it drains
   always_ff @(posedge core_clk) begin
      if (!rst_b || phase == 3'h4) begin
         phase <= 3'h0;
      end else begin
         phase <= phase + 3'h1;
      end
   end

   assign line_ready = !slow || phase == 3'h0 || phase == 3'h2;
   // A fresh word every cycle, scrambled by the bench in enhanced mode
   assign rx_word = rx_src;
endmodule : far_end_model

/* test_dc_balanced_word_line_codec.sv */
// Self-checking bench for the word line codec with encoder and decoder models
`timescale 1ns/100ps
module test_dc_balanced_word_line_codec;
   import line_code_pkg::*;
   // ************************************************************
   // Signals and model state
   // ************************************************************
   logic        core_clk;
   logic        rst_b;
   logic [15:0] tx_payload;
   logic        data_word_request;
   logic        control_word_request;
   logic        user_flag_in;
   logic        user_flag_select;
   logic        enhanced_simplex_select;
   logic        tx_ready;
   logic        line_ready;
   line_word_t  line_word;
   logic        running_sign;
   line_word_t  rx_word;
   line_word_t  rx_src;
   logic [15:0] rx_payload;
   logic        rx_flag;
   logic        rx_data_word;
   logic        control_word_indicator;
   logic        rx_error;
   logic        slow;
   integer      seed;
   int          n_mismatch;
   int          n_checks;
   tx_req_t     q[$];
   int          acc;
   logic [6:0]  s;
   logic [6:0]  ds;
   logic        alt;
   line_word_t  exp_w;
   logic [3:0]  exp_d;
   logic [15:0] exp_p;

   dc_balanced_word_line_codec #(.FIFO_DEPTH(8)) u_dut (
      .core_clk(core_clk), .rst_b(rst_b), .tx_payload(tx_payload), .data_word_request(data_word_request),
      .control_word_request(control_word_request), .user_flag_in(user_flag_in),
      .user_flag_select(user_flag_select), .enhanced_simplex_select(enhanced_simplex_select),
      .tx_ready(tx_ready), .line_ready(line_ready), .line_word(line_word), .running_sign(running_sign),
      .rx_word(rx_word), .rx_payload(rx_payload), .rx_flag(rx_flag), .rx_data_word(rx_data_word),
      .control_word_indicator(control_word_indicator), .rx_error(rx_error));

   far_end_model u_far (
      .core_clk(core_clk), .rst_b(rst_b), .slow(slow), .rx_src(rx_src), .line_ready(line_ready),
      .rx_word(rx_word));

   always #10 core_clk = ~core_clk;

   // ************************************************************
   // Expectation functions
   // ************************************************************
   function automatic line_word_t enc(input word_kind_t k, input logic [15:0] p, input logic f,
                                      input logic sg, input logic en, input logic [6:0] sc);
      line_word_t w;
      w.word   = (k == KIND_DATA) ? p : (k == KIND_CONTROL) ? {p[13:7], CTRL_MARK_TRUE, p[6:0]} :
                 sg ? IDLE_PATTERN_B_WORD : IDLE_PATTERN_A_WORD;
      w.coding = (k == KIND_DATA) ? (f ? CF_DATA_F1 : CF_DATA_F0) : (f ? CF_CTRL_F1 : CF_CTRL_F0);
      if (en) w.word[0] = w.word[0] ^ sc[1];
      // Zero-disparity words count as negative, so they invert only on a low sign
      if (k != KIND_IDLE && (($countones(w) > 10) == sg)) w = ~w;
      return w;
   endfunction : enc

   // Returns {error, control, data, flag, payload}
   function automatic logic [19:0] dec(input line_word_t r, input logic en, input logic [6:0] sc);
      line_word_t u;
      logic       bad;
      bad = (r.coding[1] == r.coding[2]) || (r.coding == CF_CTRL_INV && r.word[8:7] != 2'b01)
            || (!en && (r.coding == CF_ODD_A || r.coding == CF_ODD_B));
      u = ((r.coding[0] == r.coding[3]) ? !r.coding[0] : r.coding[0]) ? ~r : r;
      if (en) u.word[0] = u.word[0] ^ sc[1];
      if (bad) return {4'h8, 16'h0000};
      if (r.coding[0] == r.coding[3]) return {3'b001, !u.coding[1] ^ (en & sc[0]), u.word};
      if (u.word[8:7] == CTRL_MARK_TRUE) return {4'h4, 2'b00, u.word[15:9], u.word[6:0]};
      return 20'h00000;
   endfunction : dec

   always @(posedge core_clk) begin : mon_p
      tx_req_t h;
      tx_req_t r;
      logic    rdy;
      rdy = q.size() < 8;
      if (!rst_b) begin
         q.delete();
         acc = 0;
         s = SCRAMBLE_SEED;
         ds = SCRAMBLE_SEED;
         alt = 1'b0;
         exp_d = 4'h0;
         exp_w = {CF_CTRL_F0, IDLE_PATTERN_A_WORD};
      end else begin
         {exp_d, exp_p} = dec(rx_src, enhanced_simplex_select, ds);
         ds = {ds[5:0], ds[6] ^ ds[5]};
         if (line_ready) begin
            h = '{KIND_IDLE, 1'b0, 16'h0000};
            if (q.size() > 0) h = q.pop_front();
            if (h.kind == KIND_DATA && !user_flag_select) h.flag = alt & !enhanced_simplex_select;
            h.flag = h.flag ^ (enhanced_simplex_select & s[0]);
            exp_w = enc(h.kind, h.payload, h.flag, acc > 0, enhanced_simplex_select, s);
            acc = acc + 2 * $countones(exp_w) - 20;
            if (h.kind == KIND_DATA && !user_flag_select && !enhanced_simplex_select) alt = !alt;
            s = {s[5:0], s[6] ^ s[5]};
         end
         if ((data_word_request || control_word_request) && rdy) begin
            r.kind = data_word_request ? KIND_DATA : KIND_CONTROL;
            r.flag = user_flag_in & data_word_request;
            r.payload = tx_payload;
            q.push_back(r);
         end
      end
   end

   // ************************************************************
   // Compare tasks and closing report
   // ************************************************************
   task automatic chk_word(input line_word_t got, input line_word_t exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask : chk_bit

   task automatic chk_pay(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_pay

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim

   always @(negedge core_clk) begin
      chk_word(line_word, exp_w, "line word");
      chk_bit(running_sign, acc > 0, "running sign");
      chk_bit(tx_ready, q.size() < 8, "tx ready");
      chk_bit(rx_error, exp_d[3], "rx error");
      chk_bit(control_word_indicator, exp_d[2], "control flag");
      chk_bit(rx_data_word, exp_d[1], "data flag");
      chk_bit(rx_flag, exp_d[0], "rx flag");
      if (exp_d[2:1] != 2'b00) chk_pay(rx_payload, exp_p, "rx payload");
   end

   // ************************************************************
   // Stimulus
   // ************************************************************
   task automatic run(input int n, input logic en, input logic sl, input logic [3:0] dens);
      logic [31:0] r;
      logic [31:0] r2;
      for (int i = 0; i < n; i++) begin
         @(negedge core_clk);
         r = $random(seed);
         r2 = $random(seed);
         enhanced_simplex_select = en;
         slow = sl;
         tx_payload = r[31:16];
         data_word_request = r[0] & ({1'b0, r[3:1]} < dens);
         control_word_request = !r[0] & ({1'b0, r[3:1]} < dens);
         user_flag_in = r[4];
         user_flag_select = r[5];
         if (r[6]) rx_src = r2[19:0];
         else rx_src = enc(r[8] ? KIND_CONTROL : KIND_DATA, r2[15:0], r2[16], r2[17], en, r2[24:18]);
      end
   endtask : run

   task automatic drain(input logic en);
      int t;
      t = 0;
      while (q.size() > 0 && t < 100) begin
         run(1, en, 1'b1, 4'h0);
         t++;
      end
      if (q.size() > 0) begin
         n_mismatch++;
         $display("BAD %0t FIFO did not drain", $time);
         end_sim();
      end
   endtask : drain

   initial begin
      core_clk = 1'b0;
      rst_b = 1'b0;
      tx_payload = 16'h0000;
      data_word_request = 1'b0;
      control_word_request = 1'b0;
      user_flag_in = 1'b0;
      user_flag_select = 1'b0;
      enhanced_simplex_select = 1'b0;
      rx_src = 20'h00000;
      slow = 1'b0;
      seed = 32'h23256329;
      n_mismatch = 0;
      n_checks = 0;
      repeat (5) @(negedge core_clk);
      rst_b = 1'b1;
      run(400, 1'b0, 1'b0, 4'h5);
      $display("test plain traffic done");
      run(30, 1'b0, 1'b1, 4'h8);
      drain(1'b0);
      $display("test fifo fill and drain done");
      run(300, 1'b1, 1'b1, 4'h6);
      run(300, 1'b1, 1'b0, 4'h8);
      drain(1'b1);
      $display("test enhanced mode done");
      run(20, 1'b0, 1'b1, 4'h8);
      rst_b = 1'b0;
      run(3, 1'b0, 1'b0, 4'h0);
      rst_b = 1'b1;
      run(200, 1'b0, 1'b0, 4'h3);
      $display("test second reset done");
      end_sim();
   end
endmodule : test_dc_balanced_word_line_codec
